// *** design/cgc_clock_gear.sv ***
// Behaviour
// - protected registers take a value only right after the unlock word there.
// - low and next 3-bit fields pick bus and core divisors 1 to 1/32.
// - unused divider register bits read zero and ignore writes.
// - a new divisor code changes the derived rate with no reset.
// - core divisor paces peripheral enables; bus divisor does not touch them.
// - only a reset wake returns divisors to 1/1; other wakes keep them.
// - 4-bit wait field sets settle time held after a standby wake.
// - wait code 0000 waits one input clock; others below 1111 reserved.
// - wait code 1111 waits at least 10 ms, rate independent.
// - wait register bits 7..4 read one, bits above read zero.
// - wait never applies after reset release; reset held over 10 ms.
// - each listed block clock gates alone; DRAM also by its pin.
// - gated timer or pulse-width clock freezes its count until restored.
// - access to gated DMA or DRAM controller raises an abort.
// - only a reset wake re-enables clocks that software gated.
// - standby request bit stops oscillation; settle wait applies on wake.
module cgc_clock_gear #(
   parameter int SETTLE_CYCLES = cgc_pkg::SETTLE_CYCLES,
   parameter bit HAS_DIV32     = 1'b1,
   parameter bit HAS_EXT_WAIT  = 1'b1
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins
   input  wire logic        wake_req,
   input  wire logic        dram_clock_gate_pin_n,
   // peripheral access watch
   input  wire logic        dma_access,
   input  wire logic        dram_access,
   // derived clock enables
   output logic             bus_clk_en,
   output logic             core_clk_en,
   output logic [14:0]      block_clk_en,
   // power state
   output logic             osc_run,
   output logic             cpu_clk_on,
   output logic             access_abort
);

   // settle count end points
   localparam int SETTLE_W_L = cgc_pkg::SETTLE_W;
   localparam logic [SETTLE_W_L-1:0] SETTLE_LAST =
      SETTLE_W_L'(SETTLE_CYCLES - 1);
   localparam logic [SETTLE_W_L-1:0] EXT_LAST =
      SETTLE_W_L'(cgc_pkg::EXT_WAIT_CYCLES - 1);

   cgc_pkg::cgc_state_t s_reg;
   cgc_pkg::cgc_state_t s_next;

   // effective divisor shift; reserved codes fall back to full rate
   function automatic logic [4:0] div_mask(input logic [2:0] code);
      logic [2:0] c;
      c = code;
      if (code == cgc_pkg::DIV_CODE_DIV32 && !HAS_DIV32)
         c = cgc_pkg::DIV_SEL_RESET;
      else if (code > cgc_pkg::DIV_CODE_DIV32)
         c = cgc_pkg::DIV_SEL_RESET;
      // ones below the shift pick the pulse phase of the counter
      div_mask = 5'((6'h01 << c) - 6'h01);
   endfunction

   // reserved wait codes treated as crystal: the safe, longer choice
   function automatic logic [SETTLE_W_L-1:0] wait_last(
      input logic [3:0] code);
      if (code == cgc_pkg::WAIT_EXT_CLOCK && HAS_EXT_WAIT)
         wait_last = EXT_LAST;
      else if (code == cgc_pkg::WAIT_CRYSTAL)
         wait_last = SETTLE_LAST;
      else
         wait_last = SETTLE_LAST;
   endfunction

   // decode of a protected register address, one hot
   function automatic logic [2:0] prot_hit(input logic [31:0] a);
      if (a == cgc_pkg::OFS_CLOCK_STOP)
         prot_hit = 3'h1;
      else if (a == cgc_pkg::OFS_DIV_SELECT)
         prot_hit = 3'h2;
      else if (a == cgc_pkg::OFS_SETTLE_WAIT)
         prot_hit = 3'h4;
      else
         prot_hit = 3'h0;
   endfunction

   // helpers, each given a value at the top of the process
   logic        wr_done;
   logic        rd_setup;
   logic [2:0]  hit;
   logic        may_store;
   logic        run_clocks;
   logic [4:0]  bus_m;
   logic [4:0]  core_m;
   logic        dram_pin_gate;

   // next state: hold by default, then bus, divider, modes, enables
   always_comb begin
      s_next        = s_reg;
      wr_done       = psel && penable && s_reg.pready && pwrite;
      rd_setup      = psel && !penable && !s_reg.pready;
      hit           = prot_hit(paddr);
      may_store     = (hit & s_reg.unlock) != 3'h0;
      run_clocks    = 1'b0;
      bus_m         = div_mask(s_reg.bus_eff);
      core_m        = div_mask(s_reg.core_eff);
      dram_pin_gate = !s_reg.dpin_s2;

      // pins pass two flops before use
      s_next.wake_s1 = wake_req;
      s_next.wake_s2 = s_reg.wake_s1;
      s_next.dpin_s1 = dram_clock_gate_pin_n;
      s_next.dpin_s2 = s_reg.dpin_s1;

      // apb: answer one cycle after setup, data loaded with pready
      s_next.pready  = rd_setup;
      s_next.pslverr = 1'b0;
      if (rd_setup) begin
         s_next.prdata = 32'h0000_0000;
         // registers read back through one address chain
         if (paddr == cgc_pkg::OFS_CLOCK_STOP) begin
            s_next.prdata[cgc_pkg::STOP_SERIAL_BIT] = s_reg.serial_gate;
            s_next.prdata[cgc_pkg::STOP_TEST_BIT]   = s_reg.test_gate;
            s_next.prdata[cgc_pkg::STOP_HALT_BIT]   = s_reg.halt_bit;
            s_next.prdata[cgc_pkg::STOP_STANDBY_REQUEST_BIT_BIT]   = s_reg.standby_request_bit_bit;
         end else if (paddr == cgc_pkg::OFS_DIV_SELECT) begin
            s_next.prdata[cgc_pkg::BUS_SEL_LSB +: 3]  = s_reg.bus_sel;
            s_next.prdata[cgc_pkg::CORE_SEL_LSB +: 3] = s_reg.core_sel;
         end else if (paddr == cgc_pkg::OFS_SETTLE_WAIT) begin
            s_next.prdata[7:0] = {cgc_pkg::WAIT_FIXED_ONES,
                                  s_reg.wait_code};
         end else if (paddr == cgc_pkg::OFS_BLOCK_GATE) begin
            s_next.prdata[cgc_pkg::BLK_GATES-1:0] = s_reg.blk_gate;
         end else begin
            s_next.pslverr = 1'b1;
         end
      end else begin
         // data rests at zero outside the answer cycle
         s_next.prdata = 32'h0000_0000;
      end

      // writes, with key arming for protected registers
      if (wr_done) begin
         s_next.unlock = 3'h0;
         if (hit != 3'h0 && may_store) begin
            // clock stop register
            if (hit[0]) begin
               s_next.serial_gate = pwdata[cgc_pkg::STOP_SERIAL_BIT];
               s_next.test_gate   = pwdata[cgc_pkg::STOP_TEST_BIT];
               s_next.halt_bit    = pwdata[cgc_pkg::STOP_HALT_BIT];
               s_next.standby_request_bit_bit    = pwdata[cgc_pkg::STOP_STANDBY_REQUEST_BIT_BIT];
            end
            // divider fields, other bits dropped
            if (hit[1]) begin
               s_next.bus_sel  = pwdata[cgc_pkg::BUS_SEL_LSB +: 3];
               s_next.core_sel = pwdata[cgc_pkg::CORE_SEL_LSB +: 3];
            end
            // low four bits only; the upper nibble is fixed
            if (hit[2])
               s_next.wait_code = pwdata[3:0];
         end else if (hit != 3'h0 && pwdata == cgc_pkg::UNLOCK_WORD) begin
            s_next.unlock = hit;
         end else if (paddr == cgc_pkg::OFS_BLOCK_GATE) begin
            s_next.blk_gate = pwdata[cgc_pkg::BLK_GATES-1:0];
         end
      end

      // free-running divider; new codes land when all rates align
      s_next.div_cnt = s_reg.div_cnt + 5'h01;
      // the wrap is the one edge shared by every rate
      if (s_reg.div_cnt == 5'h1F) begin
         s_next.bus_eff  = s_reg.bus_sel;
         s_next.core_eff = s_reg.core_sel;
      end

      // power modes; a non-reset wake leaves divisors and gates alone
      case (s_reg.mode)
         cgc_pkg::CGC_RUN: begin
            // stop bits act the cycle after the write lands
            run_clocks = 1'b1;
            if (s_reg.standby_request_bit_bit) begin
               // no enable may leave as the oscillator stops
               run_clocks     = 1'b0;
               s_next.mode    = cgc_pkg::CGC_STANDBY;
               s_next.osc_run = 1'b0;
            end else if (s_reg.halt_bit) begin
               s_next.mode = cgc_pkg::CGC_HALT;
            end
         end
         cgc_pkg::CGC_HALT: begin
            // core and peripherals run on; only a wake ends it
            run_clocks = 1'b1;
            if (s_reg.wake_s2) begin
               s_next.mode     = cgc_pkg::CGC_RUN;
               s_next.halt_bit = 1'b0;
            end
         end
         cgc_pkg::CGC_STANDBY: begin
            // oscillator off; the wake passes the synchroniser first
            if (s_reg.wake_s2) begin
               s_next.mode       = cgc_pkg::CGC_SETTLE;
               s_next.osc_run    = 1'b1;
               s_next.settle_cnt = '0;
            end
         end
         default: begin
            // settle: clocks stay off until the count ends
            s_next.settle_cnt = s_reg.settle_cnt + 1'b1;
            if (s_reg.settle_cnt >= wait_last(s_reg.wait_code)) begin
               s_next.mode     = cgc_pkg::CGC_RUN;
               s_next.standby_request_bit_bit = 1'b0;
               s_next.halt_bit = 1'b0;
            end
         end
      endcase

      // cpu clock follows the mode being entered
      s_next.cpu_clk_on = (s_next.mode == cgc_pkg::CGC_RUN);

      // enables: core paces peripherals, bus only the bus
      s_next.bus_clk_en  = s_next.cpu_clk_on &&
                           ((s_reg.div_cnt & bus_m) == 5'h00);
      s_next.core_clk_en = run_clocks &&
                           ((s_reg.div_cnt & core_m) == 5'h00);
      // gated blocks see no enable, so their counters hold
      s_next.block_clk_en[12:0] = {13{s_next.core_clk_en}} &
                                  ~s_reg.blk_gate;
      // the pin gate overrides the software bit for dram
      if (dram_pin_gate)
         s_next.block_clk_en[cgc_pkg::BLK_DRAM_BIT] = 1'b0;
      // serial and test enables follow the clock stop register
      s_next.block_clk_en[13] = s_next.core_clk_en && !s_reg.serial_gate;
      s_next.block_clk_en[14] = s_next.core_clk_en && !s_reg.test_gate;

      // abort on access to a stopped dma or dram controller
      s_next.access_abort =
         (dma_access && s_reg.blk_gate[cgc_pkg::BLK_DMA_BIT]) ||
         (dram_access && (s_reg.blk_gate[cgc_pkg::BLK_DRAM_BIT] ||
                          dram_pin_gate));
   end

   // reset returns full rate and all clocks on, no settle wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // every field named once, so none is reset twice
         s_reg.prdata       <= 32'h0000_0000;
         s_reg.pready       <= 1'b0;
         s_reg.pslverr      <= 1'b0;
         s_reg.bus_sel      <= cgc_pkg::DIV_SEL_RESET;
         s_reg.core_sel     <= cgc_pkg::DIV_SEL_RESET;
         s_reg.bus_eff      <= cgc_pkg::DIV_SEL_RESET;
         s_reg.core_eff     <= cgc_pkg::DIV_SEL_RESET;
         s_reg.wait_code    <= cgc_pkg::WAIT_RESET;
         s_reg.serial_gate  <= 1'b0;
         s_reg.test_gate    <= 1'b0;
         s_reg.halt_bit     <= 1'b0;
         s_reg.standby_request_bit_bit     <= 1'b0;
         s_reg.blk_gate     <= cgc_pkg::BLK_GATE_RESET;
         s_reg.unlock       <= 3'h0;
         s_reg.mode         <= cgc_pkg::CGC_RUN;
         s_reg.settle_cnt   <= '0;
         s_reg.div_cnt      <= 5'h00;
         s_reg.wake_s1      <= 1'b0;
         s_reg.wake_s2      <= 1'b0;
         s_reg.dpin_s1      <= 1'b1;
         s_reg.dpin_s2      <= 1'b1;
         s_reg.bus_clk_en   <= 1'b0;
         s_reg.core_clk_en  <= 1'b0;
         s_reg.block_clk_en <= 15'h0000;
         s_reg.osc_run      <= 1'b1;
         s_reg.cpu_clk_on   <= 1'b1;
         s_reg.access_abort <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   assign prdata       = s_reg.prdata;
   assign pready       = s_reg.pready;
   assign pslverr      = s_reg.pslverr;
   assign bus_clk_en   = s_reg.bus_clk_en;
   assign core_clk_en  = s_reg.core_clk_en;
   assign block_clk_en = s_reg.block_clk_en;
   assign osc_run      = s_reg.osc_run;
   assign cpu_clk_on   = s_reg.cpu_clk_on;
   assign access_abort = s_reg.access_abort;

endmodule

// *** pkg/cgc_pkg.sv ***
package cgc_pkg;

   // register byte addresses
   localparam logic [31:0] OFS_CLOCK_STOP   = 32'hB800_0004;
   localparam logic [31:0] OFS_DIV_SELECT   = 32'hB800_0008;
   localparam logic [31:0] OFS_SETTLE_WAIT  = 32'hB800_000C;
   localparam logic [31:0] OFS_BLOCK_GATE   = 32'hB800_0010;

   // write protection key
   localparam logic [31:0] UNLOCK_WORD      = 32'h0000_003C;

   // divider register fields
   localparam int          BUS_SEL_LSB      = 0;
   localparam int          CORE_SEL_LSB     = 4;
   localparam logic [2:0]  DIV_SEL_RESET    = 3'h0;
   localparam logic [2:0]  DIV_CODE_MAX     = 3'h4;
   localparam logic [2:0]  DIV_CODE_DIV32   = 3'h5;

   // settle wait register fields
   localparam logic [3:0]  WAIT_RESET       = 4'hF;
   localparam logic [3:0]  WAIT_EXT_CLOCK   = 4'h0;
   localparam logic [3:0]  WAIT_CRYSTAL     = 4'hF;
   localparam logic [3:0]  WAIT_FIXED_ONES  = 4'hF;

   // clock stop register fields
   localparam int          STOP_SERIAL_BIT  = 0;
   localparam int          STOP_TEST_BIT    = 1;
   localparam int          STOP_HALT_BIT    = 2;
   localparam int          STOP_STANDBY_REQUEST_BIT_BIT    = 7;

   // block gate register: 13 gate bits, adc at bit 0
   localparam int          BLK_GATES        = 13;
   localparam int          BLK_DRAM_BIT     = 8;
   localparam int          BLK_DMA_BIT      = 9;
   localparam logic [12:0] BLK_GATE_RESET   = 13'h0000;

   // timing
   localparam int          CLK_MHZ          = 100;
   localparam int          SETTLE_MIN_MS    = 10;
   localparam int          SETTLE_CYCLES    = SETTLE_MIN_MS * 1000 * CLK_MHZ;
   localparam int          EXT_WAIT_CYCLES  = 1;
   localparam int          SETTLE_W         = 24;

   typedef enum logic [1:0] {
      CGC_RUN,
      CGC_HALT,
      CGC_STANDBY,
      CGC_SETTLE
   } cgc_mode_t;

   typedef struct packed {
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic [2:0]           bus_sel;
      logic [2:0]           core_sel;
      logic [2:0]           bus_eff;
      logic [2:0]           core_eff;
      logic [3:0]           wait_code;
      logic                 serial_gate;
      logic                 test_gate;
      logic                 halt_bit;
      logic                 standby_request_bit_bit;
      logic [12:0]          blk_gate;
      logic [2:0]           unlock;
      cgc_mode_t            mode;
      logic [SETTLE_W-1:0]  settle_cnt;
      logic [4:0]           div_cnt;
      logic                 wake_s1;
      logic                 wake_s2;
      logic                 dpin_s1;
      logic                 dpin_s2;
      logic                 bus_clk_en;
      logic                 core_clk_en;
      logic [14:0]          block_clk_en;
      logic                 osc_run;
      logic                 cpu_clk_on;
      logic                 access_abort;
   } cgc_state_t;

endpackage

// *** bench/cgc_clock_gear_assertions.sv ***
module cgc_clock_gear_checker (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins and access watch
   input wire logic        dram_clock_gate_pin_n,
   input wire logic        dma_access,
   input wire logic        dram_access,
   // enables and power state
   input wire logic        bus_clk_en,
   input wire logic        core_clk_en,
   input wire logic [14:0] block_clk_en,
   input wire logic        osc_run,
   input wire logic        cpu_clk_on,
   input wire logic        access_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // bus answer shape
   a_pready_answer: assert property (psel && !penable |=> pready && penable)
      else $error("no ready after setup");
   a_pready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_slverr_qualified: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_prdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   // power and gating relations
   a_standby_quiet: assert property (!osc_run |-> !cpu_clk_on && !bus_clk_en
      && !core_clk_en && block_clk_en == 15'h0000)
      else $error("clock running in standby");
   a_block_core: assert property ((block_clk_en[12:0] & ~{13{core_clk_en}})
      == 13'h0000)
      else $error("block enable without core enable");
   a_settle_hold: assert property ($rose(osc_run) |-> !cpu_clk_on)
      else $error("cpu clock on before settle");
   a_pin_gate: assert property (!dram_clock_gate_pin_n [*4]
      |-> !block_clk_en[8])
      else $error("dram clock not gated by pin");
   a_abort_pin: assert property ((!dram_clock_gate_pin_n [*4]) ##0
      dram_access |=> access_abort)
      else $error("no abort on gated dram access");
   a_abort_cause: assert property (!dma_access && !dram_access
      |=> !access_abort)
      else $error("abort without access");
endmodule

bind cgc_clock_gear cgc_clock_gear_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .dram_clock_gate_pin_n(dram_clock_gate_pin_n), .dma_access(dma_access),
   .dram_access(dram_access), .bus_clk_en(bus_clk_en),
   .core_clk_en(core_clk_en), .block_clk_en(block_clk_en),
   .osc_run(osc_run), .cpu_clk_on(cpu_clk_on), .access_abort(access_abort)
);

// *** bench/cgc_clock_gear_test.sv ***
module cgc_clock_gear_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          SETTLE = 20;
   localparam logic [31:0] DIV    = cgc_pkg::OFS_DIV_SELECT;
   localparam logic [31:0] WT     = cgc_pkg::OFS_SETTLE_WAIT;
   localparam logic [31:0] STP    = cgc_pkg::OFS_CLOCK_STOP;
   localparam logic [31:0] GATE   = cgc_pkg::OFS_BLOCK_GATE;
   logic        pclk, presetn, psel, penable, pwrite, wake_req, pin_n;
   logic        dma_access, dram_access, last_err, pready, pslverr;
   logic        bus_clk_en, core_clk_en, osc_run, cpu_clk_on, access_abort;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [14:0] block_clk_en;
   int          fail_count, checks, n;

   always #5 pclk = ~pclk;

   cgc_clock_gear #(.SETTLE_CYCLES(SETTLE)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wake_req(wake_req),
      .dram_clock_gate_pin_n(pin_n), .dma_access(dma_access),
      .dram_access(dram_access), .bus_clk_en(bus_clk_en),
      .core_clk_en(core_clk_en), .block_clk_en(block_clk_en),
      .osc_run(osc_run), .cpu_clk_on(cpu_clk_on),
      .access_abort(access_abort));

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until ready is sampled
   task automatic apb(input logic w, input logic [31:0] a, d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) fail_count++;
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // protected write: key first, value right after
   task automatic wrp(input logic [31:0] a, d);
      apb(1'b1, a, cgc_pkg::UNLOCK_WORD);
      apb(1'b1, a, d);
   endtask

   // cycles between two enable pulses, bounded
   task automatic period(input bit core, output int p);
      p = 0;
      do @(posedge pclk);
      while ((core ? core_clk_en : bus_clk_en) !== 1'b1 && p++ < 100);
      p = 0;
      do begin
         @(posedge pclk);
         p++;
      end while ((core ? core_clk_en : bus_clk_en) !== 1'b1 && p < 100);
   endtask

   // enter standby, then count cycles from wake request to cpu clock
   task automatic sleep_wake(output int p);
      wrp(STP, 32'h0000_0080);
      repeat (2) @(posedge pclk);
      check(32'(osc_run), 32'h0);
      wake_req <= 1'b1;
      p = 0;
      do begin
         @(posedge pclk);
         p++;
      end while (cpu_clk_on !== 1'b1 && p < 200);
      wake_req <= 1'b0;
   endtask

   // access pulse on one master line, abort looked at one cycle later
   task automatic poke(input bit dram, input logic exp);
      @(posedge pclk);
      if (dram) dram_access <= 1'b1;
      else dma_access <= 1'b1;
      @(posedge pclk);
      dma_access <= 1'b0;
      dram_access <= 1'b0;
      #1 check(32'(access_abort), 32'(exp));
   endtask

   task automatic stop_test;
      $display("Mismatches %0d, checks %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hang guard, far beyond the thousand or so cycles needed
   initial begin
      #500_000;
      fail_count++;
      stop_test();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, wake_req} = 6'h00;
      {dma_access, dram_access, paddr, pwdata} = 66'h0;
      pin_n = 1'b1;
      fail_count = 0;
      checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, DIV, 0); check(rd, 32'h0000_0000);
      apb(0, WT, 0); check(rd, 32'h0000_00FF);
      // no key, then key disarmed by another write
      apb(1, DIV, 32'h0000_0011); apb(0, DIV, 0); check(rd, 0);
      apb(1, DIV, cgc_pkg::UNLOCK_WORD);
      apb(1, GATE, 0);
      apb(1, DIV, 32'h0000_0011); apb(0, DIV, 0); check(rd, 0);
      wrp(DIV, 32'hFFFF_FFAB); apb(0, DIV, 0); check(rd, 32'h0000_0023);
      // divisor codes 0 to 5 on both fields, rates measured live
      for (int c = 0; c < 6; c++) begin
         wrp(DIV, {24'h0, 1'b0, 3'(5 - c), 1'b0, 3'(c)});
         repeat (70) @(posedge pclk);
         period(0, n); check(32'(n), 32'(1 << c));
         period(1, n); check(32'(n), 32'(1 << (5 - c)));
      end
      wrp(DIV, 32'h0000_0066); apb(0, DIV, 0); check(rd, 32'h0000_0066);
      wrp(WT, 32'hFFFF_FF00); apb(0, WT, 0); check(rd, 32'h0000_00F0);
      wrp(WT, 32'h0000_000F); apb(0, WT, 0); check(rd, 32'h0000_00FF);
      // gate everything, then ungate the 13 block gates; serial and test stay stopped
      apb(1, GATE, 32'h0000_1FFF);
      wrp(STP, 32'h0000_0003);
      repeat (4) @(posedge pclk);
      #1 check(32'(block_clk_en), 32'h0);
      poke(0, 1'b1);
      apb(1, GATE, 0);
      repeat (4) @(posedge pclk);
      #1 check(32'(block_clk_en), 32'h0000_1FFF);
      poke(0, 1'b0);
      pin_n <= 1'b0;
      repeat (5) @(posedge pclk);
      #1 check(32'(block_clk_en[8]), 32'h0);
      poke(1, 1'b1);
      pin_n <= 1'b1;
      apb(0, 32'hB800_0020, 0); check(32'(last_err), 32'h1);
      // non-reset wakes keep divisors and gates
      wrp(DIV, 32'h0000_0021);
      apb(1, GATE, 32'h0000_0004);
      sleep_wake(n); check(32'(n >= SETTLE && n <= SETTLE + 8), 1);
      apb(0, DIV, 0); check(rd, 32'h0000_0021);
      apb(0, GATE, 0); check(rd, 32'h0000_0004);
      wrp(WT, 32'h0000_0000);
      sleep_wake(n); check(32'(n <= 6), 1);
      // halt: cpu and bus stop, core pacing runs on, a plain wake resumes
      wrp(STP, 32'h0000_0004);
      period(1, n); check(32'(n), 32'h4);
      #1 check(32'({cpu_clk_on, bus_clk_en}), 32'h0);
      wake_req <= 1'b1;
      repeat (5) @(posedge pclk);
      #1 check(32'(cpu_clk_on), 32'h1);
      wake_req <= 1'b0;
      apb(0, DIV, 0); check(rd, 32'h0000_0021);
      // reset as wake source restores full rate, ungated, no wait
      wrp(STP, 32'h0000_0080);
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1 check(32'(cpu_clk_on), 32'h1);
      apb(0, DIV, 0); check(rd, 32'h0000_0000);
      apb(0, GATE, 0); check(rd, 32'h0000_0000);
      stop_test();
   end
endmodule
